// ==== mbrs_params.svh ====
// Constants for the register-access frame handler.
`ifndef MBRS_PARAMS_SVH
`define MBRS_PARAMS_SVH
`define MBRS_FC_READ       8'h03
`define MBRS_FC_WRITE      8'h06
`define MBRS_FC_EXC_FLAG   8'h80
`define MBRS_EXC_FUNC      8'h01
`define MBRS_EXC_ADDR      8'h02
`define MBRS_EXC_DATA      8'h03
`define MBRS_ADDR_LIMIT    17'h05800
`define MBRS_MAX_READ      16'h007d
`define MBRS_BROADCAST     8'h00
`define MBRS_CRC_INIT      16'hffff
`define MBRS_CRC_POLY      16'ha001
`define MBRS_REG_OP0_HI    16'h0480
`define MBRS_REG_OP0_LO    16'h0481
`define MBRS_REG_OP1_HI    16'h0482
`define MBRS_REG_OP1_LO    16'h0483
`define MBRS_REG_SPDLIM_LO 16'h104b
`define MBRS_REG_RESET     16'h0000
`define MBRS_QUERY_LEN     4'h8
`define MBRS_POS_CRC_HI    4'h7
`define MBRS_POS_CRC_DONE  4'h8
`endif

// ==== mbrs_pkg.sv ====
// Types shared by the register-access frame handler.
package mbrs_pkg;
  typedef enum logic [2:0] {
    MBRS_RX,
    MBRS_CHECK,
    MBRS_EXEC,
    MBRS_TX_HEAD,
    MBRS_TX_DATA,
    MBRS_TX_CRC
  } mbrs_state_t;
endpackage

// ==== mbrs_crc16.sv ====
// CRC-16 byte update unit, reflected polynomial, initial all ones.
`timescale 1ns/100ps
`include "mbrs_params.svh"
module mbrs_crc16 (
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  always_comb
  begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++)
    begin
      if (crc_out[0])
        crc_out = (crc_out >> 1) ^ `MBRS_CRC_POLY;
      else
        crc_out = crc_out >> 1;
    end
  end
endmodule

// ==== mbrs_slave.sv ====
// Frame handler for 03h register reads and 06h single writes.
// Operation
// - Execute only functions 03h and 06h.
// - Read returns one to 125 16-bit registers.
// - Read registers in ascending address order.
// - Read reply echoes header, byte count doubled.
// - Each register sent high byte first.
// - CRC-16 trailer, low byte first.
// - Single write stores value only if the address is one of the five mapped registers.
// - Exception reply: function plus 80h, code, check.
// - Broadcast executes but sends no reply.
// - Address out of range gives exception 02h.
// - Zero or excess count gives exception 03h.
`timescale 1ns/100ps
`include "mbrs_params.svh"
module mbrs_slave (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  slave_addr_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_frame_end_in,
  output logic      [7:0]  tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic             tx_frame_end_out,
  output logic             busy_out
);
  mbrs_pkg::mbrs_state_t state_reg, state_next;
  logic [7:0]  buf_reg [8];
  logic [7:0]  buf_next [8];
  logic [3:0]  cnt_reg, cnt_next;
  logic [15:0] crc_reg, crc_next;
  logic [15:0] idx_reg, idx_next;
  logic        hi_reg, hi_next;
  logic [7:0]  exc_reg, exc_next;
  logic [15:0] regs_reg [5];
  logic [15:0] regs_next [5];
  logic [7:0]  tx_data_reg, tx_data_next;
  logic        tx_valid_reg, tx_valid_next;
  logic        end_reg, end_next;
  logic [7:0]  crc_byte;
  logic [15:0] crc_upd;
  logic [15:0] start_addr, count, wval, rd_addr, rd_val;
  logic [16:0] span;
  logic        rd_hit;

  // Each address that a query touches is either one of ours or reads as 0.
  localparam logic [15:0] REG_MAP [5] = '{`MBRS_REG_OP0_HI, `MBRS_REG_OP0_LO,
    `MBRS_REG_OP1_HI, `MBRS_REG_OP1_LO, `MBRS_REG_SPDLIM_LO};

  assign start_addr = {buf_reg[2], buf_reg[3]};
  assign count      = {buf_reg[4], buf_reg[5]};
  assign wval       = count;
  assign span       = {1'b0, start_addr} + {1'b0, count};
  assign rd_addr    = start_addr + idx_reg;

  always_comb
  begin
    rd_val = 16'h0000;
    rd_hit = 1'b0;
    for (int i = 0; i < 5; i++)
      if (rd_addr == REG_MAP[i])
      begin
        rd_val = regs_reg[i];
        rd_hit = 1'b1;
      end
  end

  mbrs_crc16 u_crc (
    .crc_in  (crc_reg),
    .data_in (crc_byte),
    .crc_out (crc_upd)
  );

  assign tx_data_out      = tx_data_reg;
  assign tx_valid_out     = tx_valid_reg;
  assign tx_frame_end_out = end_reg;
  assign busy_out         = (state_reg != mbrs_pkg::MBRS_RX);

  always_comb
  begin
    state_next    = state_reg;
    buf_next      = buf_reg;
    cnt_next      = cnt_reg;
    crc_next      = crc_reg;
    idx_next      = idx_reg;
    hi_next       = hi_reg;
    exc_next      = exc_reg;
    regs_next     = regs_reg;
    tx_data_next  = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    end_next      = 1'b0;
    crc_byte      = rx_data_in;
    case (state_reg)
      mbrs_pkg::MBRS_RX:
      begin
        if (rx_valid_in)
        begin
          crc_next = crc_upd;
          // Count one past a full query so that a long frame fails the check.
          if (cnt_reg < `MBRS_QUERY_LEN)
            buf_next[cnt_reg[2:0]] = rx_data_in;
          if (cnt_reg <= `MBRS_QUERY_LEN)
            cnt_next = cnt_reg + 4'h1;
        end
        if (rx_frame_end_in)
          state_next = mbrs_pkg::MBRS_CHECK;
      end
      mbrs_pkg::MBRS_CHECK:
      begin
        // A good frame leaves a zero residue over data plus trailer.
        if (cnt_reg != `MBRS_QUERY_LEN || crc_reg != 16'h0000 ||
            (buf_reg[0] != slave_addr_in &&
             buf_reg[0] != `MBRS_BROADCAST))
          state_next = mbrs_pkg::MBRS_RX;
        else
          state_next = mbrs_pkg::MBRS_EXEC;
        cnt_next = 4'h0;
        crc_next = `MBRS_CRC_INIT;
      end
      mbrs_pkg::MBRS_EXEC:
      begin
        exc_next = 8'h00;
        idx_next = 16'h0000;
        hi_next  = 1'b1;
        if (buf_reg[1] == `MBRS_FC_READ)
        begin
          if (count == 16'h0000 || count > `MBRS_MAX_READ)
            exc_next = `MBRS_EXC_DATA;
          else if (span >= `MBRS_ADDR_LIMIT)
            exc_next = `MBRS_EXC_ADDR;
        end
        else if (buf_reg[1] == `MBRS_FC_WRITE)
        begin
          if ({1'b0, start_addr} >= `MBRS_ADDR_LIMIT)
            exc_next = `MBRS_EXC_ADDR;
          else
            for (int i = 0; i < 5; i++)
              if (start_addr == REG_MAP[i])
                regs_next[i] = wval;
        end
        else
          exc_next = `MBRS_EXC_FUNC;
        if (buf_reg[0] == `MBRS_BROADCAST)
          state_next = mbrs_pkg::MBRS_RX;
        else
          state_next = mbrs_pkg::MBRS_TX_HEAD;
      end
      mbrs_pkg::MBRS_TX_HEAD:
      begin
        // Header bytes: address, function, then a per-function tail.
        if (!tx_valid_reg || tx_ready_in)
        begin
          tx_valid_next = 1'b1;
          cnt_next = cnt_reg + 4'h1;
          case (cnt_reg)
            4'h0: tx_data_next = buf_reg[0];
            4'h1: tx_data_next = (exc_reg != 8'h00) ?
                    (buf_reg[1] | `MBRS_FC_EXC_FLAG) : buf_reg[1];
            4'h2:
            begin
              if (exc_reg != 8'h00)
                tx_data_next = exc_reg;
              else if (buf_reg[1] == `MBRS_FC_READ)
                tx_data_next = {count[6:0], 1'b0};
              else
                tx_data_next = buf_reg[2];
            end
            default: tx_data_next = buf_reg[cnt_reg[2:0]];
          endcase
          if (cnt_reg == 4'h2 && (exc_reg != 8'h00 ||
              buf_reg[1] == `MBRS_FC_READ))
            state_next = (exc_reg != 8'h00) ? mbrs_pkg::MBRS_TX_CRC
                                              : mbrs_pkg::MBRS_TX_DATA;
          else if (cnt_reg == 4'h5)
            state_next = mbrs_pkg::MBRS_TX_CRC;
          crc_byte = tx_data_next;
          crc_next = crc_upd;
        end
      end
      mbrs_pkg::MBRS_TX_DATA:
      begin
        if (tx_ready_in)
        begin
          tx_data_next = hi_reg ? rd_val[15:8] : rd_val[7:0];
          hi_next = ~hi_reg;
          if (!hi_reg)
            idx_next = idx_reg + 16'h0001;
          if (!hi_reg && idx_reg + 16'h0001 == count)
          begin
            state_next = mbrs_pkg::MBRS_TX_CRC;
            cnt_next = 4'h0;
          end
          crc_byte = tx_data_next;
          crc_next = crc_upd;
        end
      end
      mbrs_pkg::MBRS_TX_CRC:
      begin
        // The counter tracks the trailer, since the end flag is a one-cycle
        // pulse that may pass while the sink stalls.
        if (tx_ready_in)
        begin
          if (cnt_reg == `MBRS_POS_CRC_DONE)
          begin
            tx_valid_next = 1'b0;
            cnt_next = 4'h0;
            crc_next = `MBRS_CRC_INIT;
            state_next = mbrs_pkg::MBRS_RX;
          end
          else if (cnt_reg == `MBRS_POS_CRC_HI)
          begin
            tx_data_next = crc_reg[15:8];
            end_next = 1'b1;
            cnt_next = `MBRS_POS_CRC_DONE;
          end
          else
          begin
            tx_data_next = crc_reg[7:0];
            cnt_next = `MBRS_POS_CRC_HI;
          end
        end
      end
      default: state_next = mbrs_pkg::MBRS_RX;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg    <= mbrs_pkg::MBRS_RX;
      cnt_reg      <= 4'h0;
      crc_reg      <= `MBRS_CRC_INIT;
      idx_reg      <= 16'h0000;
      hi_reg       <= 1'b1;
      exc_reg      <= 8'h00;
      tx_data_reg  <= 8'h00;
      tx_valid_reg <= 1'b0;
      end_reg      <= 1'b0;
      for (int i = 0; i < 8; i++)
        buf_reg[i] <= 8'h00;
      for (int i = 0; i < 5; i++)
        regs_reg[i] <= `MBRS_REG_RESET;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      crc_reg      <= crc_next;
      idx_reg      <= idx_next;
      hi_reg       <= hi_next;
      exc_reg      <= exc_next;
      tx_data_reg  <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      end_reg      <= end_next;
      buf_reg      <= buf_next;
      regs_reg     <= regs_next;
    end
  end
endmodule

// ==== mbrs_slave_assertions.sv ====
// Port-level checks on the register-access frame handler.
`timescale 1ns/100ps
module mbrs_slave_assertions (
  input logic       sys_clk_in,
  input logic       sys_rst_in,
  input logic [7:0] slave_addr_in,
  input logic [7:0] rx_data_in,
  input logic       rx_valid_in,
  input logic       rx_frame_end_in,
  input logic [7:0] tx_data_out,
  input logic       tx_valid_out,
  input logic       tx_ready_in,
  input logic       tx_frame_end_out,
  input logic       busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rst;
    $fell(sys_rst_in) |-> !tx_valid_out && !busy_out;
  endproperty
  a_rst: assert property (p_rst) else $error("live after reset");
  property p_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_end;
    tx_frame_end_out |-> tx_valid_out;
  endproperty
  a_end: assert property (p_end) else $error("end flag alone");
  property p_drop;
    tx_frame_end_out && tx_ready_in |=> !tx_valid_out;
  endproperty
  a_drop: assert property (p_drop) else $error("byte after crc");
  property p_idle;
    !busy_out |-> !tx_valid_out;
  endproperty
  a_idle: assert property (p_idle) else $error("send while idle");
  property p_lat;
    $rose(tx_valid_out) |-> $past(rx_frame_end_in, 4);
  endproperty
  a_lat: assert property (p_lat) else $error("reply timing");
  property p_addr;
    $rose(tx_valid_out) |-> tx_data_out == slave_addr_in;
  endproperty
  a_addr: assert property (p_addr) else $error("reply address");
  property p_busy;
    rx_frame_end_in && !busy_out |=> busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("frame not taken");
  c_exc: cover property ($rose(tx_valid_out) ##1 tx_data_out[7]);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
  c_done: cover property (tx_frame_end_out && tx_ready_in);
endmodule
bind mbrs_slave mbrs_slave_assertions i_chk (.*);

// ==== mbrs_master.sv ====
// Bus master model: sends queries with their check field, gathers replies.
`timescale 1ns/100ps
module mbrs_master (
  input  logic       clk_in,
  output logic [7:0] rx_data_out,
  output logic       rx_valid_out,
  output logic       rx_end_out,
  input  logic [7:0] tx_data_in,
  input  logic       tx_valid_in,
  output logic       tx_ready_out
);
  logic [7:0]  rq[$];
  logic [15:0] rcrc;
  logic        slow;
  initial
  begin
    {rx_data_out, rx_valid_out, rx_end_out, slow} = 11'h000;
    tx_ready_out = 1'b1;
    rcrc = 16'hffff;
  end
  function automatic logic [15:0] crc(input logic [15:0] c, logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // A good reply leaves a zero residue once its own check bytes are folded in.
  always @(posedge clk_in)
  begin
    if (tx_valid_in && tx_ready_out)
    begin
      rq.push_back(tx_data_in);
      rcrc <= crc(rcrc, tx_data_in);
    end
    tx_ready_out <= #1 slow ? ~tx_ready_out : 1'b1;
  end
  task automatic clear;
    rq.delete();
    rcrc = 16'hffff;
  endtask
  task automatic send(input logic [47:0] body, input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 5; i >= 0; i--)
      c = crc(c, body[i*8 +: 8]);
    c[0] = c[0] ^ bad;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_in);
      #1;
      rx_valid_out = 1'b1;
      rx_data_out = i < 6 ? body[(5-i)*8 +: 8] : c[(i-6)*8 +: 8];
    end
    @(posedge clk_in);
    #1;
    rx_valid_out = 1'b0;
    rx_data_out = ~rx_data_out;
    rx_end_out = 1'b1;
    @(posedge clk_in);
    #1;
    rx_end_out = 1'b0;
  endtask
endmodule

// ==== mbrs_slave_tb.sv ====
// Self-checking bench for the register-access frame handler.
`timescale 1ns/100ps
module mbrs_slave_tb;
  logic       sys_clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic [7:0] slave_addr_in = 8'h01;
  logic [7:0] rx_data_in, tx_data_out;
  logic       rx_valid_in, rx_frame_end_in, tx_valid_out;
  logic       tx_ready_in, tx_frame_end_out, busy_out;
  int         miscompares = 0;
  int         compares = 0;
  int         ends = 0;
  mbrs_slave i_mbrs_slave (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .slave_addr_in(slave_addr_in),
    .rx_data_in(rx_data_in),
    .rx_valid_in(rx_valid_in),
    .rx_frame_end_in(rx_frame_end_in),
    .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in),
    .tx_frame_end_out(tx_frame_end_out),
    .busy_out(busy_out)
  );
  // One end pulse is expected for every reply frame.
  always @(posedge sys_clk_in)
    if (tx_frame_end_out === 1'b1)
      ends <= ends + 1;
  mbrs_master i_mbrs_master (
    .clk_in(sys_clk_in),
    .rx_data_out(rx_data_in),
    .rx_valid_out(rx_valid_in),
    .rx_end_out(rx_frame_end_in),
    .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in)
  );
  initial
  begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Leading reply bytes, at most eleven, stand right-aligned in e.
  task automatic xfer(input logic [47:0] q, logic bad, int n, logic [87:0] e);
    int k;
    k = n > 13 ? 11 : n - 2;
    ends = 0;
    i_mbrs_master.clear();
    i_mbrs_master.send(q, bad);
    repeat (3) @(posedge sys_clk_in);
    #1;
    for (int t = 0; busy_out !== 1'b0 || i_mbrs_master.rq.size() < n; t++)
    begin
      if (t > 600)
      begin
        miscompares++;
        test_done();
      end
      @(posedge sys_clk_in);
      #1;
    end
    check("length", 16'(i_mbrs_master.rq.size()), 16'(n));
    check("ends", 16'(ends), 16'(n > 0));
    if (n > 0)
      check("residue", i_mbrs_master.rcrc, 16'h0000);
    for (int i = 0; i < k; i++)
      check("byte", i_mbrs_master.rq[i], e[(k-1-i)*8 +: 8]);
    $display("query %h done", q);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    xfer(48'h010304800004, 0, 13, 88'h0103080000000000000000);
    i_mbrs_master.slow = 1'b1;
    xfer(48'h0106048101f4, 0, 8, 48'h0106048101f4);
    xfer(48'h0106048309c4, 0, 8, 48'h0106048309c4);
    xfer(48'h0106104b03e8, 0, 8, 48'h0106104b03e8);
    xfer(48'h01060480ffff, 1, 0, 88'h0);
    xfer(48'h000604821234, 0, 0, 88'h0);
    xfer(48'h020604801111, 0, 0, 88'h0);
    xfer(48'h01030480007d, 0, 255, 88'h0103fa000001f4123409c4);
    xfer(48'h0104104b0001, 0, 5, 24'h018401);
    xfer(48'h010300000000, 0, 5, 24'h018303);
    xfer(48'h01030000007e, 0, 5, 24'h018303);
    xfer(48'h010357ff0001, 0, 5, 24'h018302);
    xfer(48'h010357fe0001, 0, 7, 40'h0103020000);
    xfer(48'h010658000001, 0, 5, 24'h018602);
    xfer(48'h0103104b0001, 0, 7, 40'h01030203e8);
    test_done();
  end
endmodule
